/* rtl/tcc_pkg.sv */
package tcc_pkg;
    // Register byte offsets
    localparam logic [11:0] TCC_ADDR_TEX_CTRL = 12'h000;
    localparam logic [11:0] TCC_ADDR_TEX_CFG = 12'h004;
    localparam logic [11:0] TCC_ADDR_TEX_LOD = 12'h008;
    localparam logic [11:0] TCC_ADDR_TEX_LEVEL = 12'h00C;
    localparam logic [11:0] TCC_ADDR_SMP_CTRL = 12'h010;
    localparam logic [11:0] TCC_ADDR_SMP_LOD = 12'h014;
    localparam logic [11:0] TCC_ADDR_STATUS = 12'h018;
    // Sampling control word layout (texture and sampler share it)
    localparam int TCC_CTRL_W = 14;
    localparam int TCC_MIN_LSB = 0;
    localparam int TCC_MAG_BIT = 3;
    localparam int TCC_WRAP_S_LSB = 4;
    localparam int TCC_WRAP_T_LSB = 6;
    localparam int TCC_WRAP_R_LSB = 8;
    localparam int TCC_CMP_MODE_BIT = 10;
    localparam int TCC_CMP_FUNC_LSB = 11;
    localparam int TCC_SMP_BOUND_BIT = 31;
    // Texture configuration word
    localparam int TCC_CFG_W = 4;
    localparam int TCC_FMT_LSB = 0;
    localparam int TCC_MIPC_BIT = 3;
    // Status word
    localparam int TCC_ST_COMPLETE_BIT = 0;
    localparam int TCC_ST_MIPS_BIT = 1;
    localparam int TCC_ST_BUSY_BIT = 2;
    typedef enum logic [2:0] {
        TCC_NEAREST_FILTER = 3'h0,
        TCC_LINEAR_FILTER = 3'h1,
        TCC_POINT_SINGLE_LEVEL_FILTER = 3'h2,
        TCC_LINEAR_SINGLE_LEVEL_FILTER = 3'h3,
        TCC_POINT_BLEND_LEVELS_FILTER = 3'h4,
        TCC_LINEAR_BLEND_LEVELS_FILTER = 3'h5
    } tcc_min_filter_t;
    localparam logic TCC_MAG_NEAREST = 1'h0;
    localparam logic TCC_MAG_LINEAR = 1'h1;
    typedef enum logic [1:0] {
        TCC_REPEAT_WRAP = 2'h0,
        TCC_EDGE_CLAMP_WRAP = 2'h1,
        TCC_MIRROR_WRAP = 2'h2
    } tcc_wrap_t;
    typedef enum logic [2:0] {
        TCC_CMP_LESS_OR_EQUAL = 3'h0,
        TCC_CMP_GREATER_OR_EQUAL = 3'h1,
        TCC_CMP_LESS = 3'h2,
        TCC_CMP_GREATER = 3'h3,
        TCC_CMP_EQUAL = 3'h4,
        TCC_CMP_NOT_EQUAL = 3'h5,
        TCC_CMP_ALWAYS = 3'h6,
        TCC_CMP_NEVER = 3'h7
    } tcc_cmp_func_t;
    typedef enum logic [2:0] {
        TCC_FMT_RGBA8 = 3'h0,
        TCC_SRGB_WITH_ALPHA_FORMAT = 3'h1,
        TCC_SHARED_EXPONENT_FORMAT = 3'h2,
        TCC_FMT_DEPTH24 = 3'h3,
        TCC_FMT_DEPTH32F = 3'h4,
        TCC_FMT_DEPTH24_STENCIL8 = 3'h5
    } tcc_format_t;
    // Reset values
    localparam logic [13:0] TCC_CTRL_RST = 14'(TCC_POINT_BLEND_LEVELS_FILTER)
        | (14'(TCC_MAG_LINEAR) << TCC_MAG_BIT) | (14'(TCC_CMP_LESS_OR_EQUAL) << TCC_CMP_FUNC_LSB);
    localparam logic [13:0] TCC_CTRL_RECT_RST = 14'(TCC_LINEAR_FILTER)
        | (14'(TCC_MAG_LINEAR) << TCC_MAG_BIT) | (14'(TCC_EDGE_CLAMP_WRAP) << TCC_WRAP_S_LSB)
        | (14'(TCC_EDGE_CLAMP_WRAP) << TCC_WRAP_T_LSB) | (14'(TCC_EDGE_CLAMP_WRAP) << TCC_WRAP_R_LSB)
        | (14'(TCC_CMP_LESS_OR_EQUAL) << TCC_CMP_FUNC_LSB);
    localparam logic [15:0] TCC_LOD_LOWER_RST = 16'hFC18;
    localparam logic [15:0] TCC_LOD_UPPER_RST = 16'h03E8;
    localparam logic [15:0] TCC_BASE_LEVEL_RST = 16'h0000;
    localparam logic [15:0] TCC_MAX_LEVEL_RST = 16'h03E8;
    // Number formats: channels are unsigned 16.16 fixed point
    localparam int TCC_FX_FRAC = 16;
    localparam logic [31:0] TCC_FX_ONE = 32'h0001_0000;
    localparam logic [23:0] TCC_UNORM24_MAX = 24'hFFFFFF;
    localparam logic [7:0] TCC_FP_SAT_EXP = 8'h8E;
    localparam logic [7:0] TCC_FP_UNITY_EXP = 8'h7E;
    localparam int TCC_SAMPLES = 4;
    localparam int TCC_LUT_DEPTH = 256;
    localparam int TCC_LUT_W = 17;
    localparam int TCC_RGBE_MANT_W = 9;
    localparam int TCC_RGBE_EXP_W = 5;
    localparam int TCC_RGBE_EXP_LSB = 27;
    localparam int TCC_RGBE_BIAS = 15;
    localparam real TCC_SRGB_KNEE = 0.04045;
    localparam real TCC_SRGB_SLOPE = 12.92;
    localparam real TCC_SRGB_OFFSET = 0.055;
    localparam real TCC_SRGB_SCALE = 1.055;
    localparam real TCC_SRGB_GAMMA = 2.4;
    typedef enum logic [1:0] {
        TCC_ST_IDLE = 2'b00,
        TCC_ST_CONV = 2'b01,
        TCC_ST_OUT = 2'b10
    } tcc_state_t;
endpackage : tcc_pkg

/* rtl/tcc_srgb_lut.sv */
`timescale 1ns/1ps
module tcc_srgb_lut
    import tcc_pkg::*;
(
    // Clock and control
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic en_in,
    // Lookup
    input wire logic [7:0] addr_in,
    output logic [TCC_LUT_W-1:0] data_out
);
    // Table built at elaboration; no image file needed
    function automatic logic [TCC_LUT_W-1:0] srgb_entry(input int idx);
        real cs;
        real cl;
        cs = idx / 255.0;
        if (cs <= TCC_SRGB_KNEE)
            cl = cs / TCC_SRGB_SLOPE;
        else
            cl = ((cs + TCC_SRGB_OFFSET) / TCC_SRGB_SCALE) ** TCC_SRGB_GAMMA;
        return TCC_LUT_W'($rtoi(cl * 65536.0 + 0.5));
    endfunction : srgb_entry

    logic [TCC_LUT_W-1:0] rom [TCC_LUT_DEPTH];
    logic [TCC_LUT_W-1:0] data_r;

    for (genvar gi = 0; gi < TCC_LUT_DEPTH; gi++)
    begin : g_rom
        assign rom[gi] = srgb_entry(gi);
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            data_r <= '0;
        else if (en_in)
            data_r <= rom[addr_in];
    end
    assign data_out = data_r;
endmodule : tcc_srgb_lut

/* rtl/tcc_rgbe_dec.sv */
`timescale 1ns/1ps
module tcc_rgbe_dec
    import tcc_pkg::*;
(
    // Packed shared-exponent texel
    input wire logic [31:0] texel_in,
    // Red, green, blue in 16.16
    output logic [2:0][31:0] chan_out
);
    logic [TCC_RGBE_EXP_W-1:0] exp_w;
    logic [5:0] shift_w;
    assign exp_w = texel_in[TCC_RGBE_EXP_LSB +: TCC_RGBE_EXP_W];
    // Mantissa * 2^(exp - bias), rescaled into 16 fraction bits
    assign shift_w = 6'(exp_w) + 6'(TCC_FX_FRAC - TCC_RGBE_BIAS);
    for (genvar gc = 0; gc < 3; gc++)
    begin : g_chan
        assign chan_out[gc] = 32'(texel_in[gc*TCC_RGBE_MANT_W +: TCC_RGBE_MANT_W]) << shift_w;
    end
endmodule : tcc_rgbe_dec

/* rtl/tcc_unit.sv */
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module tcc_unit
    import tcc_pkg::*;
#(
    parameter bit RECT_TARGET = 1'b0
)
(
    // Clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Lookup request from the shader core
    input wire logic lk_valid_in,
    output logic lk_ready_out,
    input wire logic [31:0] lk_ref_in,
    input wire logic [TCC_SAMPLES-1:0][31:0] lk_texel_in,
    // Filtered texel value
    output logic res_valid_out,
    input wire logic res_ready_in,
    output logic [31:0] res_red_out,
    output logic [31:0] res_green_out,
    output logic [31:0] res_blue_out,
    output logic [31:0] res_alpha_out,
    // Effective sampling state for the addressing logic
    output tcc_pkg::tcc_min_filter_t eff_min_filter_out,
    output logic eff_magnify_filter_sel_out,
    output tcc_pkg::tcc_wrap_t eff_wrap_s_out,
    output tcc_pkg::tcc_wrap_t eff_wrap_t_out,
    output tcc_pkg::tcc_wrap_t eff_wrap_r_out,
    output logic [15:0] eff_lod_lower_clamp_out,
    output logic [15:0] eff_lod_upper_clamp_out,
    output logic [15:0] base_level_out,
    output logic [15:0] max_level_out,
    output logic unit_complete_out
);
    import tcc_pkg::*;

    localparam logic [13:0] CTRL_RST = RECT_TARGET ? TCC_CTRL_RECT_RST : TCC_CTRL_RST;

    function automatic logic [39:0] fp_to_q40(input logic [31:0] f);
        logic [7:0] e;
        logic [63:0] m;
        e = f[30:23];
        m = {40'h0, 1'b1, f[22:0]};
        if (f[31] || e == 8'h00)
            return '0;
        if (e > TCC_FP_SAT_EXP)
            return '1;
        if (e >= TCC_FP_UNITY_EXP)
            return 40'(m << (e - TCC_FP_UNITY_EXP));
        return 40'(m >> (TCC_FP_UNITY_EXP - e));
    endfunction : fp_to_q40

    function automatic logic [31:0] fp_order_key(input logic [31:0] f);
        return f[31] ? ~f : {1'b1, f[30:0]};
    endfunction : fp_order_key

    function automatic logic depth_test(input logic [2:0] fn, input logic lt, input logic eq);
        case (fn)
            TCC_CMP_LESS_OR_EQUAL: return lt | eq;
            TCC_CMP_GREATER_OR_EQUAL: return !lt;
            TCC_CMP_LESS: return lt;
            TCC_CMP_GREATER: return !lt && !eq;
            TCC_CMP_EQUAL: return eq;
            TCC_CMP_NOT_EQUAL: return !eq;
            TCC_CMP_ALWAYS: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : depth_test

    function automatic logic [31:0] unorm8_fx(input logic [7:0] c);
        return (c == 8'hFF) ? TCC_FX_ONE : {16'h0000, c, c};
    endfunction : unorm8_fx

    function automatic logic is_depth(input logic [2:0] fmt);
        return fmt == TCC_FMT_DEPTH24 || fmt == TCC_FMT_DEPTH32F
            || fmt == TCC_FMT_DEPTH24_STENCIL8;
    endfunction : is_depth

    // Register state
    logic [13:0] tex_ctrl_r;
    logic [3:0] tex_cfg_r;
    logic [31:0] tex_lod_r;
    logic [31:0] tex_level_r;
    logic [13:0] smp_ctrl_r;
    logic smp_bound_r;
    logic [31:0] smp_lod_r;
    logic [31:0] prdata_r;

    // APB decode
    logic apb_setup;
    logic apb_access;
    logic addr_hit;
    logic wr_en;
    logic [31:0] rd_word;
    assign apb_setup = psel_in && !penable_in;
    assign apb_access = psel_in && penable_in;
    assign addr_hit = paddr_in == TCC_ADDR_TEX_CTRL || paddr_in == TCC_ADDR_TEX_CFG
        || paddr_in == TCC_ADDR_TEX_LOD || paddr_in == TCC_ADDR_TEX_LEVEL
        || paddr_in == TCC_ADDR_SMP_CTRL || paddr_in == TCC_ADDR_SMP_LOD
        || paddr_in == TCC_ADDR_STATUS;
    // Zero wait states; a frozen block holds the bus off instead of losing a write
    assign pready_out = ce_in;
    assign pslverr_out = apb_access && !addr_hit;
    assign wr_en = ce_in && apb_access && pwrite_in && addr_hit;

    // Effective sampling state
    logic [13:0] eff_ctrl;
    logic [31:0] eff_lod;
    logic mips_needed;
    logic unit_complete;
    logic [2:0] eff_min;
    tcc_state_t state_r;
    tcc_state_t state_nxt;
    assign eff_ctrl = smp_bound_r ? smp_ctrl_r : tex_ctrl_r;
    assign eff_lod = smp_bound_r ? smp_lod_r : tex_lod_r;
    assign eff_min = eff_ctrl[TCC_MIN_LSB +: 3];
    assign mips_needed = eff_min != TCC_NEAREST_FILTER && eff_min != TCC_LINEAR_FILTER;
    assign unit_complete = !(mips_needed && !tex_cfg_r[TCC_MIPC_BIT]);

    assign rd_word =
        (paddr_in == TCC_ADDR_TEX_CTRL) ? 32'(tex_ctrl_r) :
        (paddr_in == TCC_ADDR_TEX_CFG) ? 32'(tex_cfg_r) :
        (paddr_in == TCC_ADDR_TEX_LOD) ? tex_lod_r :
        (paddr_in == TCC_ADDR_TEX_LEVEL) ? tex_level_r :
        (paddr_in == TCC_ADDR_SMP_CTRL) ? ({smp_bound_r, 31'h0} | 32'(smp_ctrl_r)) :
        (paddr_in == TCC_ADDR_SMP_LOD) ? smp_lod_r :
        (paddr_in == TCC_ADDR_STATUS) ? ((32'(state_r != TCC_ST_IDLE) << TCC_ST_BUSY_BIT)
            | (32'(mips_needed) << TCC_ST_MIPS_BIT)
            | (32'(unit_complete) << TCC_ST_COMPLETE_BIT)) :
        32'h0000_0000;

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            tex_ctrl_r <= CTRL_RST;
            tex_cfg_r <= '0;
            tex_lod_r <= {TCC_LOD_UPPER_RST, TCC_LOD_LOWER_RST};
            tex_level_r <= {TCC_MAX_LEVEL_RST, TCC_BASE_LEVEL_RST};
            smp_ctrl_r <= TCC_CTRL_RST;
            smp_bound_r <= 1'b0;
            smp_lod_r <= {TCC_LOD_UPPER_RST, TCC_LOD_LOWER_RST};
            prdata_r <= '0;
        end
        else if (ce_in)
        begin
            if (apb_setup && !pwrite_in)
                prdata_r <= rd_word;
            if (wr_en && paddr_in == TCC_ADDR_TEX_CTRL)
                tex_ctrl_r <= pwdata_in[TCC_CTRL_W-1:0];
            if (wr_en && paddr_in == TCC_ADDR_TEX_CFG)
                tex_cfg_r <= pwdata_in[TCC_CFG_W-1:0];
            if (wr_en && paddr_in == TCC_ADDR_TEX_LOD)
                tex_lod_r <= pwdata_in;
            if (wr_en && paddr_in == TCC_ADDR_TEX_LEVEL)
                tex_level_r <= pwdata_in;
            if (wr_en && paddr_in == TCC_ADDR_SMP_CTRL)
            begin
                smp_ctrl_r <= pwdata_in[TCC_CTRL_W-1:0];
                smp_bound_r <= pwdata_in[TCC_SMP_BOUND_BIT];
            end
            if (wr_en && paddr_in == TCC_ADDR_SMP_LOD)
                smp_lod_r <= pwdata_in;
        end
    end
    assign prdata_out = prdata_r;

    // Effective state registered for the addressing logic
    logic [13:0] eff_ctrl_r;
    logic [31:0] eff_lod_r;
    logic complete_r;
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            eff_ctrl_r <= CTRL_RST;
            eff_lod_r <= {TCC_LOD_UPPER_RST, TCC_LOD_LOWER_RST};
            complete_r <= 1'b0;
        end
        else if (ce_in)
        begin
            eff_ctrl_r <= eff_ctrl;
            eff_lod_r <= eff_lod;
            complete_r <= unit_complete;
        end
    end
    assign eff_min_filter_out = tcc_min_filter_t'(eff_ctrl_r[TCC_MIN_LSB +: 3]);
    assign eff_magnify_filter_sel_out = eff_ctrl_r[TCC_MAG_BIT];
    assign eff_wrap_s_out = tcc_wrap_t'(eff_ctrl_r[TCC_WRAP_S_LSB +: 2]);
    assign eff_wrap_t_out = tcc_wrap_t'(eff_ctrl_r[TCC_WRAP_T_LSB +: 2]);
    assign eff_wrap_r_out = tcc_wrap_t'(eff_ctrl_r[TCC_WRAP_R_LSB +: 2]);
    assign eff_lod_lower_clamp_out = eff_lod_r[15:0];
    assign eff_lod_upper_clamp_out = eff_lod_r[31:16];
    assign base_level_out = tex_level_r[15:0];
    assign max_level_out = tex_level_r[31:16];
    assign unit_complete_out = complete_r;

    // Lookup sequencing
    logic accept;
    logic multi;
    assign lk_ready_out = state_r == TCC_ST_IDLE;
    assign accept = ce_in && lk_valid_in && state_r == TCC_ST_IDLE;
    // Filtering past one texel compares several depths
    assign multi = eff_ctrl[TCC_MAG_BIT] != TCC_MAG_NEAREST
        || !(eff_min == TCC_NEAREST_FILTER || eff_min == TCC_POINT_SINGLE_LEVEL_FILTER);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            TCC_ST_IDLE: if (lk_valid_in) state_nxt = TCC_ST_CONV;
            TCC_ST_CONV: state_nxt = TCC_ST_OUT;
            TCC_ST_OUT: if (res_ready_in) state_nxt = TCC_ST_IDLE;
            default: state_nxt = TCC_ST_IDLE;
        endcase
    end

    // Snapshot so mid-lookup writes cannot tear a result
    logic [TCC_SAMPLES-1:0][31:0] texel_r;
    logic [31:0] ref_r;
    logic [2:0] fmt_r;
    logic cmp_on_r;
    logic [2:0] func_r;
    logic multi_r;
    logic lk_complete_r;
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            state_r <= TCC_ST_IDLE;
            texel_r <= '0;
            ref_r <= '0;
            fmt_r <= TCC_FMT_RGBA8;
            cmp_on_r <= 1'b0;
            func_r <= TCC_CMP_LESS_OR_EQUAL;
            multi_r <= 1'b0;
            lk_complete_r <= 1'b0;
        end
        else if (ce_in)
        begin
            state_r <= state_nxt;
            if (accept)
            begin
                texel_r <= lk_texel_in;
                ref_r <= lk_ref_in;
                fmt_r <= tex_cfg_r[TCC_FMT_LSB +: 3];
                cmp_on_r <= eff_ctrl[TCC_CMP_MODE_BIT];
                func_r <= eff_ctrl[TCC_CMP_FUNC_LSB +: 3];
                multi_r <= multi;
                lk_complete_r <= unit_complete;
            end
        end
    end

    // Reference depth, clamped into [0,1] as unorm24 for fixed formats
    logic [39:0] ref_q40;
    logic [23:0] ref_unorm;
    logic [31:0] ref_key;
    logic fixed_depth;
    assign ref_q40 = fp_to_q40(ref_r);
    assign ref_unorm = (ref_q40 > 40'(TCC_UNORM24_MAX)) ? TCC_UNORM24_MAX : ref_q40[23:0];
    assign ref_key = fp_order_key(ref_r);
    assign fixed_depth = fmt_r != TCC_FMT_DEPTH32F;

    // Per-sample conversion ahead of the box filter
    logic [TCC_SAMPLES-1:0][3:0][31:0] s_chan;
    for (genvar gi = 0; gi < TCC_SAMPLES; gi++)
    begin : g_smp
        logic [2:0][31:0] rgbe_ch;
        logic [2:0][TCC_LUT_W-1:0] lin_ch;
        logic [23:0] d_fix;
        logic [39:0] d_q40;
        logic lt;
        logic eq;
        logic pass;
        logic [31:0] d_val;
        logic [31:0] d_red;

        tcc_rgbe_dec u_rgbe (
            .texel_in(texel_r[gi]),
            .chan_out(rgbe_ch)
        );
        for (genvar gc = 0; gc < 3; gc++)
        begin : g_lut
            // Read launches at accept, ready by CONV
            tcc_srgb_lut u_lut (
                .ref_clk_in(ref_clk_in),
                .rst_n_in(rst_n_in),
                .en_in(accept),
                .addr_in(lk_texel_in[gi][8*gc +: 8]),
                .data_out(lin_ch[gc])
            );
        end

        assign d_fix = texel_r[gi][23:0];
        assign d_q40 = fp_to_q40(texel_r[gi]);
        // Unorm texels lie in [0,1] already; float is unclamped
        assign lt = fixed_depth ? (ref_unorm < d_fix)
            : (ref_key < fp_order_key(texel_r[gi]));
        assign eq = fixed_depth ? (ref_unorm == d_fix)
            : (ref_key == fp_order_key(texel_r[gi]));
        assign pass = depth_test(func_r, lt, eq);
        assign d_val = fixed_depth
            ? ((d_fix == TCC_UNORM24_MAX) ? TCC_FX_ONE : {16'h0000, d_fix[23:8]})
            : d_q40[39:8];
        assign d_red = cmp_on_r ? (pass ? TCC_FX_ONE : 32'h0000_0000) : d_val;

        always_comb
        begin
            s_chan[gi] = '0;
            case (fmt_r)
                TCC_SRGB_WITH_ALPHA_FORMAT:
                begin
                    for (int c = 0; c < 3; c++)
                        s_chan[gi][c] = 32'(lin_ch[c]);
                    s_chan[gi][3] = unorm8_fx(texel_r[gi][31:24]);
                end
                TCC_SHARED_EXPONENT_FORMAT:
                begin
                    for (int c = 0; c < 3; c++)
                        s_chan[gi][c] = rgbe_ch[c];
                    s_chan[gi][3] = TCC_FX_ONE;
                end
                TCC_FMT_DEPTH24, TCC_FMT_DEPTH32F, TCC_FMT_DEPTH24_STENCIL8:
                begin
                    s_chan[gi][0] = d_red;
                    s_chan[gi][3] = TCC_FX_ONE;
                end
                default:
                begin
                    for (int c = 0; c < 4; c++)
                        s_chan[gi][c] = unorm8_fx(texel_r[gi][8*c +: 8]);
                end
            endcase
        end
    end

    // Equal-weight filter: compare on gives passes / samples
    logic [3:0][33:0] chan_sum;
    logic [3:0][31:0] chan_res;
    for (genvar gc = 0; gc < 4; gc++)
    begin : g_filter
        assign chan_sum[gc] = 34'(s_chan[0][gc]) + 34'(s_chan[1][gc])
            + 34'(s_chan[2][gc]) + 34'(s_chan[3][gc]);
        assign chan_res[gc] = !lk_complete_r ? ((gc == 3) ? TCC_FX_ONE : 32'h0000_0000)
            : multi_r ? chan_sum[gc][33:2] : s_chan[0][gc];
    end

    logic [3:0][31:0] res_r;
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            res_r <= '0;
        else if (ce_in && state_r == TCC_ST_CONV)
            res_r <= chan_res;
    end
    assign res_valid_out = state_r == TCC_ST_OUT;
    assign res_red_out = res_r[0];
    assign res_green_out = res_r[1];
    assign res_blue_out = res_r[2];
    assign res_alpha_out = res_r[3];
endmodule : tcc_unit

/* verification/tcc_unit_properties.sv */
`timescale 1ns/1ps
module tcc_unit_checker
    import tcc_pkg::*;
(
    // Watched ports
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic lk_valid_in,
    input wire logic lk_ready_out,
    input wire logic res_valid_out,
    input wire logic res_ready_in,
    input wire logic [31:0] res_red_out,
    input tcc_pkg::tcc_min_filter_t eff_min_filter_out,
    input wire logic eff_magnify_filter_sel_out,
    input tcc_pkg::tcc_wrap_t eff_wrap_s_out,
    input wire logic [15:0] eff_lod_lower_clamp_out,
    input wire logic [15:0] eff_lod_upper_clamp_out,
    input wire logic [15:0] max_level_out,
    input wire logic unit_complete_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_rst_flt; $rose(rst_n_in) |-> eff_min_filter_out == TCC_POINT_BLEND_LEVELS_FILTER
        && eff_magnify_filter_sel_out == TCC_MAG_LINEAR; endproperty
    a_rst_flt: assert property (p_rst_flt) else $error("bad filter reset");
    property p_rst_wrap; $rose(rst_n_in) |-> eff_wrap_s_out == TCC_REPEAT_WRAP; endproperty
    a_rst_wrap: assert property (p_rst_wrap) else $error("bad wrap reset");
    property p_rst_lod; $rose(rst_n_in) |-> eff_lod_lower_clamp_out == 16'hFC18
        && eff_lod_upper_clamp_out == 16'h03E8; endproperty
    a_rst_lod: assert property (p_rst_lod) else $error("bad lod reset");
    property p_rst_lvl; $rose(rst_n_in) |-> max_level_out == 16'h03E8; endproperty
    a_rst_lvl: assert property (p_rst_lvl) else $error("bad max level");
    property p_cmpl; eff_min_filter_out inside {TCC_NEAREST_FILTER, TCC_LINEAR_FILTER}
        |-> unit_complete_out; endproperty
    a_cmpl: assert property (p_cmpl) else $error("unit incomplete");
    property p_lat; lk_valid_in && lk_ready_out && ce_in |=> !lk_ready_out ##1 res_valid_out;
    endproperty
    a_lat: assert property (p_lat) else $error("result not on time");
    property p_hold; res_valid_out && !(res_ready_in && ce_in)
        |=> res_valid_out && $stable(res_red_out); endproperty
    a_hold: assert property (p_hold) else $error("result dropped");
    property p_busy; res_valid_out |-> !lk_ready_out; endproperty
    a_busy: assert property (p_busy) else $error("ready while busy");
    c_accept: cover property (lk_valid_in && lk_ready_out);
    c_stall: cover property (res_valid_out && !res_ready_in);
    c_cmpl: cover property (!unit_complete_out ##1 unit_complete_out);
endmodule : tcc_unit_checker
bind tcc_unit tcc_unit_checker chk_u (.ref_clk_in, .rst_n_in, .ce_in, .lk_valid_in,
    .lk_ready_out, .res_valid_out, .res_ready_in, .res_red_out, .eff_min_filter_out,
    .eff_magnify_filter_sel_out, .eff_wrap_s_out, .eff_lod_lower_clamp_out,
    .eff_lod_upper_clamp_out, .max_level_out, .unit_complete_out);

/* verification/tcc_core_model.sv */
`timescale 1ns/1ps
module tcc_core_model
    import tcc_pkg::*;
(
    // Clock, reset, bench control
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic req_in,
    input wire logic slow_in,
    input wire logic [31:0] ref_in,
    input wire logic [127:0] tex_in,
    // Lookup handshake
    input wire logic lk_ready_in,
    output logic lk_valid_out,
    output logic [31:0] lk_ref_out,
    output logic [TCC_SAMPLES-1:0][31:0] lk_texel_out,
    output logic res_ready_out
);
    logic [31:0] ref_r;
    logic [127:0] tex_r;
    logic [1:0] cnt_r;
    // Idle lines show the inverse, so stale data cannot pass for a request
    assign lk_ref_out = lk_valid_out ? ref_r : ~ref_r;
    assign lk_texel_out = lk_valid_out ? tex_r : ~tex_r;
    assign res_ready_out = !slow_in || cnt_r == 2'h0;
    always_ff @(posedge ref_clk_in)
    begin
        cnt_r <= rst_n_in ? cnt_r + 2'h1 : 2'h0;
        if (!rst_n_in)
            {lk_valid_out, ref_r, tex_r} <= '0;
        else if (req_in)
            {lk_valid_out, ref_r, tex_r} <= {1'b1, ref_in, tex_in};
        else if (lk_ready_in)
            lk_valid_out <= 1'b0;
    end
endmodule : tcc_core_model

/* verification/tcc_unit_bench.sv */
`timescale 1ns/1ps
module tcc_unit_bench;
    import tcc_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, req = 0, slow = 0, pr, pe, er, lkv, lkr, rv, rr;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, prd, rd, rf = 0, lref, r, a, t, lv = 32'h766CFD4A;
    logic [127:0] tx = 0;
    logic [TCC_SAMPLES-1:0][31:0] ltex;
    logic [7:0] c;
    logic [11:0] ra[4] = '{12'h000, 12'h010, 12'h008, 12'h00C};
    logic [31:0] rx[4] = '{32'h0000000C, 32'h0000000C, 32'h03E8FC18, 32'h03E80000};
    logic [31:0] fl[3] = '{32'h3E800000, 32'h3F000000, 32'h3F400000};
    int mismatches = 0, checks = 0;
    tcc_unit #(.RECT_TARGET(1'b0)) dut_u (.ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(pr), .pslverr_out(pe), .lk_valid_in(lkv),
        .lk_ready_out(lkr), .lk_ref_in(lref), .lk_texel_in(ltex), .res_valid_out(rv),
        .res_ready_in(rr), .res_red_out(r), .res_green_out(), .res_blue_out(),
        .res_alpha_out(a), .eff_min_filter_out(), .eff_magnify_filter_sel_out(),
        .eff_wrap_s_out(), .eff_wrap_t_out(), .eff_wrap_r_out(), .eff_lod_lower_clamp_out(),
        .eff_lod_upper_clamp_out(), .base_level_out(), .max_level_out(), .unit_complete_out());
    tcc_core_model core_u (.ref_clk_in(clk), .rst_n_in(rst_n), .req_in(req), .slow_in(slow),
        .ref_in(rf), .tex_in(tx), .lk_ready_in(lkr), .lk_valid_out(lkv), .lk_ref_out(lref),
        .lk_texel_out(ltex), .res_ready_out(rr));
    function automatic logic [31:0] nx(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : nx
    function automatic logic [31:0] cmpf(int f, int k);
        logic p;
        case (f)
            0: p = k <= 1;
            1: p = k >= 1;
            2: p = k < 1;
            3: p = k > 1;
            4: p = k == 1;
            5: p = k != 1;
            6: p = 1'b1;
            default: p = 1'b0;
        endcase
        return p ? TCC_FX_ONE : 32'h0;
    endfunction : cmpf
    function automatic logic [31:0] srgb(logic [7:0] v);
        real x;
        x = v / 255.0;
        x = x <= 0.04045 ? x / 12.92 : ((x + 0.055) / 1.055) ** 2.4;
        return 32'($rtoi(x * 65536.0 + 0.5));
    endfunction : srgb
    task chk(logic [31:0] s, logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task apb(logic w, logic [11:0] ad, logic [31:0] d);
        @(posedge clk);
        {psel, pwr, pa, pwd} <= {1'b1, w, ad, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pr !== 1'b1);
        rd = prd;
        er = pe;
        {psel, pen} <= 2'b00;
    endtask : apb
    // Alpha of all ones: not judged
    task look(logic [31:0] rv_, logic [127:0] tv, logic [31:0] er_, logic [31:0] ea);
        lv = nx(lv);
        @(posedge clk);
        {req, rf, tx, slow} <= {1'b1, rv_, tv, lv[0]};
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk iff (rv === 1'b1 && rr === 1'b1));
        chk(r, er_);
        if (ea !== '1) chk(a, ea);
    endtask : look
    task give_verdict;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    initial forever #20 clk = ~clk;
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict;
    end
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ra[i])
        begin
            apb(1'b0, ra[i], 32'h0);
            chk(rd, rx[i]);
        end
        apb(1'b0, 12'h01C, 32'h0);
        chk(32'(er), 32'h1);
        apb(1'b1, 12'h004, 32'hC);
        for (int f = 0; f < 8; f++)
        begin
            apb(1'b1, 12'h000, 32'h400 | 32'(f) << 11);
            for (int k = 0; k < 3; k++) look(fl[k], {4{fl[1]}}, cmpf(f, k), TCC_FX_ONE);
        end
        apb(1'b1, 12'h000, 32'h408);
        look(fl[1], {32'h3F800000, fl[2], fl[1], fl[0]}, 32'hC000, TCC_FX_ONE);
        apb(1'b1, 12'h004, 32'hB);
        apb(1'b1, 12'h000, 32'h400);
        look(32'h40000000, {4{32'h00FFFFFF}}, TCC_FX_ONE, TCC_FX_ONE);
        look(32'h40000000, {4{32'h00800000}}, 32'h0, TCC_FX_ONE);
        apb(1'b1, 12'h000, 32'h0);
        look(32'h0, {4{32'h00800000}}, 32'h8000, TCC_FX_ONE);
        apb(1'b1, 12'h004, 32'h8);
        apb(1'b1, 12'h000, 32'h1C00);
        look(32'h0, '1, TCC_FX_ONE, TCC_FX_ONE);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h000, 32'h4);
        look(32'h0, '1, 32'h0, TCC_FX_ONE);
        apb(1'b1, 12'h010, 32'h80000000);
        look(32'h0, '1, TCC_FX_ONE, TCC_FX_ONE);
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h004, 32'h9);
        apb(1'b1, 12'h000, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            c = i == 0 ? 8'h0A : i == 1 ? 8'hFF : lv[7:0];
            look(32'h0, {16{c}}, srgb(c), c == 8'hFF ? TCC_FX_ONE : {16'h0, c, c});
        end
        apb(1'b1, 12'h004, 32'hA);
        repeat (4)
        begin
            t = {2'b00, lv[29:0]};
            look(32'h0, {4{t}}, 32'(t[8:0]) << (t[31:27] + 6'd1), '1);
        end
        give_verdict;
    end
endmodule : tcc_unit_bench
